// file: hdl/asp_params.svh
// Purpose: constants for the serial port with timer baud generation
// Assumes: single core clock domain
// Notes: macros name the timer wrap, prescaler compare points, frame bit counts and bit indices
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_TIMER_WRAP 8'hFF
`define ASP_DIV4 6'h03
`define ASP_DIV8 6'h07
`define ASP_DIV12 6'h0B
`define ASP_DIV12_B 6'h17
`define ASP_DIV12_C 6'h23
`define ASP_DIV48 6'h2F
`define ASP_BITS_8 4'hA
`define ASP_BITS_9 4'hB
`define ASP_NINTH_IDX 4'h9
`define ASP_SAMPLE_PHASE 1'h1
`define ASP_ZERO8 8'h00
`define ASP_ZERO4 4'h0
`define ASP_ZERO6 6'h00
`define ASP_STOP_IDX 4'h8
`endif

// file: hdl/asp_pkg.sv
// Purpose: types shared by the serial port files
// Assumes: constants live in asp_params.svh
// Notes: clock source codes follow the selection order
package asp_pkg;
    typedef enum logic [2:0] {
        ASP_SRC_CORE,
        ASP_SRC_CORE_DIV4,
        ASP_SRC_CORE_DIV12,
        ASP_SRC_CORE_DIV48,
        ASP_SRC_EXT_OSC_DIV8,
        ASP_SRC_EXT_INPUT
    } asp_clk_src_type;
    typedef enum logic [1:0] {
        ASP_RX_IDLE,
        ASP_RX_SHIFT,
        ASP_RX_STOP
    } asp_rx_state_type;
endpackage : asp_pkg

// file: hdl/asp_skid_buffer.sv
// Purpose: two-entry buffer between receive shifter and holding register
// Assumes: one clock, synchronous active-low reset
// Notes: in_ready_o low only when both entries hold words
`timescale 1ns/1ps
module asp_skid_buffer #(
    parameter int WIDTH = 9
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be positive");
    end
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] count;
    } asp_skid_state_type;
    asp_skid_state_type st;
    asp_skid_state_type next_st;
    logic push;
    logic pop;
    always_comb begin
        next_st = st;
        push = in_valid_i && (st.count != 2'h2);
        pop = out_ready_i && (st.count != 2'h0);
        if (pop) begin
            next_st.mem[0] = st.mem[1];
        end
        if (push) begin
            if (st.count == 2'h0 || (st.count == 2'h1 && pop)) begin
                next_st.mem[0] = in_data_i;
            end else begin
                next_st.mem[1] = in_data_i;
            end
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign in_ready_o = (st.count != 2'h2);
    assign out_valid_o = (st.count != 2'h0);
    assign out_data_o = st.mem[0];
endmodule : asp_skid_buffer

// file: hdl/asp_serial_port.sv
// Purpose: full-duplex async serial port with 8-bit auto-reload baud timer
// Assumes: core clock 10 MHz; pins and external clocks synchronised here
// Notes: no bus; control bits are plain ports, data buffer by strobes
`timescale 1ns/1ps
`include "asp_params.svh"

module asp_serial_port (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic frame_length_select_i,
    input wire logic multiproc_filter_on_i,
    input wire logic receiver_on_i,
    input wire logic transmit_ninth_bit_i,
    input wire logic serial_interrupt_enable_i,
    input wire logic timer_run_i,
    input wire logic [2:0] timer_clock_select_i,
    input wire logic [7:0] baud_reload_byte_i,
    input wire logic ext_osc_clk_i,
    input wire logic timer_external_input_i,
    input wire logic data_write_i,
    input wire logic [7:0] data_write_value_i,
    input wire logic transmit_done_clear_i,
    input wire logic receive_done_clear_i,
    input wire logic rx_pin_i,
    output logic tx_pin_o,
    output logic [7:0] serial_data_buffer_o,
    output logic received_ninth_bit_o,
    output logic transmit_done_flag_o,
    output logic receive_done_flag_o,
    output logic interrupt_request_o,
    output logic transmit_busy_o
);
    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] osc_sync;
        logic [1:0] ext_sync;
        logic osc_last;
        logic ext_last;
        logic rx_last;
        logic [5:0] prescale;
        logic [2:0] osc_prescale;
        logic [7:0] tx_count;
        logic [7:0] rx_count;
        logic tx_half;
        logic rx_half;
        logic [10:0] tx_shift;
        logic [3:0] tx_left;
        logic tx_active;
        logic tx_pin;
        asp_pkg::asp_rx_state_type rx_state;
        logic [3:0] rx_index;
        logic [8:0] rx_shift;
        logic [7:0] data_buf;
        logic ninth;
        logic tx_done;
        logic rx_done;
        logic irq;
    } asp_state_type;
    asp_state_type st;
    asp_state_type next_st;
    logic tick;
    logic tx_ovf;
    logic rx_ovf;
    logic tx_bit;
    logic rx_bit;
    logic start_edge;
    logic rx_in;
    logic push_valid;
    logic push_ready;
    logic [8:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [8:0] pop_data;
    logic accept;
    logic filter_ok;
    logic tx_done_set;
    logic [3:0] tx_frame_bits;
    logic [3:0] rx_last_index;
    // ------------------------------------------------------------
    // receive holding path
    // ------------------------------------------------------------
    // word waits here while flag is set, so shifter keeps running
    asp_skid_buffer #(
        .WIDTH(9)
    ) asp_skid_buffer_inst (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(push_valid),
        .in_data_i(push_data),
        .in_ready_o(push_ready),
        .out_valid_o(pop_valid),
        .out_data_o(pop_data),
        .out_ready_i(pop_ready)
    );
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // bit counter and shifter hold at most eleven bits
    if (`ASP_BITS_9 > 4'hB || `ASP_BITS_8 >= `ASP_BITS_9) begin : g_bad_frame
        $error("frame bit counts do not fit the transmit shifter");
    end
    if (`ASP_NINTH_IDX != `ASP_STOP_IDX + 4'h1) begin : g_bad_index
        $error("ninth bit index must follow the last data index");
    end
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // ------------------------------------------------------------
        // input synchronisers
        // ------------------------------------------------------------
        // only the second stage feeds logic
        next_st.rx_sync = {st.rx_sync[0], rx_pin_i};
        next_st.osc_sync = {st.osc_sync[0], ext_osc_clk_i};
        next_st.ext_sync = {st.ext_sync[0], timer_external_input_i};
        next_st.osc_last = st.osc_sync[1];
        next_st.ext_last = st.ext_sync[1];
        rx_in = st.rx_sync[1];
        next_st.rx_last = rx_in;
        // ------------------------------------------------------------
        // timer clock source
        // ------------------------------------------------------------
        // every source is reduced to single core-clock ticks
        if (st.prescale == `ASP_DIV48) begin
            next_st.prescale = `ASP_ZERO6;
        end else begin
            next_st.prescale = st.prescale + 6'h01;
        end
        if (st.osc_sync[1] && !st.osc_last) begin
            next_st.osc_prescale = st.osc_prescale + 3'h1;
        end
        tick = 1'b0;
        unique case (asp_pkg::asp_clk_src_type'(timer_clock_select_i))
            asp_pkg::ASP_SRC_CORE: tick = 1'b1;
            asp_pkg::ASP_SRC_CORE_DIV4: tick = (st.prescale[1:0] == 2'(`ASP_DIV4));
            asp_pkg::ASP_SRC_CORE_DIV12: begin
                tick = (st.prescale == `ASP_DIV12) || (st.prescale == `ASP_DIV12_B) ||
                    (st.prescale == `ASP_DIV12_C) || (st.prescale == `ASP_DIV48);
            end
            asp_pkg::ASP_SRC_CORE_DIV48: tick = (st.prescale == `ASP_DIV48);
            // oscillator slower than half core clock; it runs apart from core clock
            asp_pkg::ASP_SRC_EXT_OSC_DIV8: begin
                tick = st.osc_sync[1] && !st.osc_last && (st.osc_prescale == 3'(`ASP_DIV8));
            end
            asp_pkg::ASP_SRC_EXT_INPUT: tick = st.ext_sync[1] && !st.ext_last;
            default: tick = 1'b0;
        endcase
        tick = tick && timer_run_i;
        // ------------------------------------------------------------
        // baud counters
        // ------------------------------------------------------------
        tx_ovf = tick && (st.tx_count == `ASP_TIMER_WRAP);
        rx_ovf = tick && (st.rx_count == `ASP_TIMER_WRAP);
        if (tick) begin
            next_st.tx_count = tx_ovf ? baud_reload_byte_i : st.tx_count + 8'h01;
            next_st.rx_count = rx_ovf ? baud_reload_byte_i : st.rx_count + 8'h01;
        end
        if (tx_ovf) begin
            next_st.tx_half = !st.tx_half;
        end
        if (rx_ovf) begin
            next_st.rx_half = !st.rx_half;
        end
        tx_bit = tx_ovf && st.tx_half;
        rx_bit = rx_ovf && (st.rx_half == `ASP_SAMPLE_PHASE);
        start_edge = (st.rx_state == asp_pkg::ASP_RX_IDLE) && receiver_on_i && st.rx_last && !rx_in;
        // first overflow after the forced reload falls mid start bit
        if (start_edge) begin
            next_st.rx_count = baud_reload_byte_i;
            next_st.rx_half = `ASP_SAMPLE_PHASE;
        end
        // ------------------------------------------------------------
        // transmitter
        // ------------------------------------------------------------
        if (frame_length_select_i) begin
            tx_frame_bits = `ASP_BITS_9;
        end else begin
            tx_frame_bits = `ASP_BITS_8;
        end
        // stop bit takes the last tick; busy falls only once it has stood
        tx_done_set = st.tx_active && tx_bit && (st.tx_left == 4'h1);
        if (data_write_i && !st.tx_active) begin
            next_st.tx_shift = {1'b1, transmit_ninth_bit_i, data_write_value_i, 1'b0};
            if (!frame_length_select_i) begin
                next_st.tx_shift = {2'b11, data_write_value_i, 1'b0};
            end
            next_st.tx_left = tx_frame_bits;
            next_st.tx_active = 1'b1;
        end else if (st.tx_active && tx_bit) begin
            if (st.tx_left == `ASP_ZERO4) begin
                next_st.tx_active = 1'b0;
            end else begin
                next_st.tx_pin = st.tx_shift[0];
                next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
                next_st.tx_left = st.tx_left - 4'h1;
            end
        end
        // set wins over a clear in the same cycle
        if (tx_done_set) begin
            next_st.tx_done = 1'b1;
        end else if (transmit_done_clear_i) begin
            next_st.tx_done = 1'b0;
        end
        if (!st.tx_active) begin
            next_st.tx_pin = 1'b1;
        end
        // ------------------------------------------------------------
        // receiver
        // ------------------------------------------------------------
        push_valid = 1'b0;
        push_data = st.rx_shift;
        filter_ok = 1'b1;
        if (frame_length_select_i) begin
            rx_last_index = `ASP_NINTH_IDX;
        end else begin
            rx_last_index = `ASP_STOP_IDX;
        end
        unique case (st.rx_state)
            asp_pkg::ASP_RX_IDLE: begin
                if (start_edge) begin
                    next_st.rx_state = asp_pkg::ASP_RX_SHIFT;
                    next_st.rx_index = `ASP_ZERO4;
                end
            end
            asp_pkg::ASP_RX_SHIFT: begin
                if (rx_bit) begin
                    if (st.rx_index == `ASP_ZERO4 && rx_in) begin
                        next_st.rx_state = asp_pkg::ASP_RX_IDLE;
                    end else if (st.rx_index != `ASP_ZERO4) begin
                        next_st.rx_shift = {rx_in, st.rx_shift[8:1]};
                    end
                    next_st.rx_index = st.rx_index + 4'h1;
                    if (st.rx_index == rx_last_index) begin
                        next_st.rx_state = asp_pkg::ASP_RX_STOP;
                    end
                end
            end
            asp_pkg::ASP_RX_STOP: begin
                if (rx_bit) begin
                    // 9-bit: ninth stays, stop ignored; 8-bit: stop becomes ninth
                    push_data = frame_length_select_i ? st.rx_shift : {rx_in, st.rx_shift[8:1]};
                    filter_ok = !multiproc_filter_on_i || push_data[8];
                    push_valid = filter_ok;
                    next_st.rx_state = asp_pkg::ASP_RX_IDLE;
                end
            end
            default: next_st.rx_state = asp_pkg::ASP_RX_IDLE;
        endcase
        // ------------------------------------------------------------
        // holding register and flags
        // ------------------------------------------------------------
        // holding register loads only while receive flag is clear
        accept = pop_valid && !st.rx_done;
        pop_ready = accept;
        if (accept) begin
            next_st.data_buf = pop_data[7:0];
            next_st.ninth = pop_data[8];
        end
        next_st.rx_done = accept || (st.rx_done && !receive_done_clear_i);
        next_st.irq = serial_interrupt_enable_i && (next_st.tx_done || next_st.rx_done);
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
            st.rx_sync <= 2'h3;
            st.rx_last <= 1'b1;
            st.tx_pin <= 1'b1;
            st.rx_state <= asp_pkg::ASP_RX_IDLE;
        end else begin
            st <= next_st;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tx_pin_o = st.tx_pin;
    assign serial_data_buffer_o = st.data_buf;
    assign received_ninth_bit_o = st.ninth;
    assign transmit_done_flag_o = st.tx_done;
    assign receive_done_flag_o = st.rx_done;
    assign interrupt_request_o = st.irq;
    assign transmit_busy_o = st.tx_active;
    // push_ready low drops a third word: overrun keeps earlier bytes
    logic unused_ready;
    assign unused_ready = push_ready;
endmodule : asp_serial_port

// file: verif/asp_serial_port_monitor.sv
// Purpose: port-level checks of the serial port
// Assumes: bit-hold check only with the core clock source
// Notes: bound to every serial port instance
`timescale 1ns/1ps
module asp_serial_port_monitor (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic serial_interrupt_enable_i,
    input wire logic [2:0] timer_clock_select_i,
    input wire logic data_write_i,
    input wire logic transmit_done_clear_i,
    input wire logic tx_pin_o,
    input wire logic [7:0] serial_data_buffer_o,
    input wire logic transmit_done_flag_o,
    input wire logic receive_done_flag_o,
    input wire logic interrupt_request_o,
    input wire logic transmit_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ----------
    // properties
    // ----------
    a_irq_follows_flags: assert property (serial_interrupt_enable_i && $past(serial_interrupt_enable_i)
        && $stable({transmit_done_flag_o, receive_done_flag_o})
        |-> interrupt_request_o == (transmit_done_flag_o || receive_done_flag_o)) else $error("irq mismatch");
    a_irq_masked_off: assert property (!serial_interrupt_enable_i && !$past(serial_interrupt_enable_i)
        |-> !interrupt_request_o) else $error("irq while disabled");
    a_tx_flag_sticky: assert property (transmit_done_flag_o && !transmit_done_clear_i
        |=> transmit_done_flag_o) else $error("tx flag dropped");
    a_rx_hold_stable: assert property (receive_done_flag_o && $past(receive_done_flag_o)
        |-> $stable(serial_data_buffer_o)) else $error("holding reg changed");
    a_idle_line_high: assert property (!transmit_busy_o |-> tx_pin_o) else $error("line low when idle");
    a_write_starts_tx: assert property (data_write_i && !transmit_busy_o |=> transmit_busy_o)
        else $error("write not taken");
    a_done_at_stop: assert property ($rose(transmit_done_flag_o) |-> transmit_busy_o && tx_pin_o)
        else $error("done not at stop bit");
    a_bit_hold_min: assert property ($changed(tx_pin_o) && timer_clock_select_i == 3'h0
        |=> $stable(tx_pin_o)) else $error("bit too short");
endmodule : asp_serial_port_monitor

bind asp_serial_port asp_serial_port_monitor asp_serial_port_monitor_inst (.core_clk_i, .reset_n_i,
    .serial_interrupt_enable_i, .timer_clock_select_i, .data_write_i, .transmit_done_clear_i, .tx_pin_o,
    .serial_data_buffer_o, .transmit_done_flag_o, .receive_done_flag_o, .interrupt_request_o, .transmit_busy_o);

// file: verif/asp_remote_port.sv
// Purpose: far-end serial transceiver model
// Assumes: bit length given in core clock cycles
// Notes: receive side keeps only the last frame
`timescale 1ns/1ps
module asp_remote_port (
    input wire logic core_clk_i,
    input wire logic tx_line_i,
    input wire logic nine_bits_i,
    input wire logic [15:0] bit_cycles_i,
    output logic rx_line_o,
    output logic [8:0] captured_o,
    output logic [7:0] frame_count_o
);
    logic [8:0] shift;
    int n;
    initial begin
        rx_line_o = 1'b1;
        captured_o = 9'h000;
        frame_count_o = 8'h00;
    end
    // ---------------
    // send / receive
    // ---------------
    task automatic send_frame(input logic [8:0] word);
        logic [10:0] bits;
        bits = nine_bits_i ? {1'b1, word, 1'b0} : {2'b11, word[7:0], 1'b0};
        for (int i = 0; i < (nine_bits_i ? 11 : 10); i++) begin
            @(posedge core_clk_i);
            rx_line_o <= bits[i];
            repeat (bit_cycles_i - 16'h0001) @(posedge core_clk_i);
        end
    endtask : send_frame
    // sampled mid-bit on the falling clock edge, clear of the launch edge
    always begin
        @(negedge tx_line_i);
        repeat (bit_cycles_i / 16'h0002 + bit_cycles_i) @(negedge core_clk_i);
        for (n = 0; n < 9; n++) begin
            shift[n] = tx_line_i;
            if (n < 8) repeat (bit_cycles_i) @(negedge core_clk_i);
        end
        captured_o <= shift;
        frame_count_o <= frame_count_o + 8'h01;
    end
endmodule : asp_remote_port

// file: verif/asp_serial_port_tb.sv
// Purpose: self-checking bench for the serial port
// Assumes: remote model on both line pins
// Notes: every timer clock source carries one transmit frame
`timescale 1ns/1ps
module asp_serial_port_tb;
    logic core_clk_i, reset_n_i, frame_length_select_i, multiproc_filter_on_i, receiver_on_i;
    logic transmit_ninth_bit_i, serial_interrupt_enable_i, timer_run_i, ext_osc_clk_i, timer_external_input_i;
    logic data_write_i, transmit_done_clear_i, receive_done_clear_i, rx_pin_i, tx_pin_o, received_ninth_bit_o;
    logic transmit_done_flag_o, receive_done_flag_o, interrupt_request_o, transmit_busy_o;
    logic [2:0] timer_clock_select_i;
    logic [7:0] baud_reload_byte_i, data_write_value_i, serial_data_buffer_o, frame_count;
    logic [8:0] captured;
    logic [15:0] bit_cycles;
    int fail_count, compares;
    // bit length per source with reload 8'hFE and external pins toggling each cycle
    localparam logic [15:0] CYC [6] = '{16'h0004, 16'h0010, 16'h0030, 16'h00C0, 16'h0040, 16'h0008};
    asp_serial_port asp_serial_port_inst (.core_clk_i, .reset_n_i, .frame_length_select_i, .multiproc_filter_on_i,
        .receiver_on_i, .transmit_ninth_bit_i, .serial_interrupt_enable_i, .timer_run_i, .timer_clock_select_i,
        .baud_reload_byte_i, .ext_osc_clk_i, .timer_external_input_i, .data_write_i, .data_write_value_i,
        .transmit_done_clear_i, .receive_done_clear_i, .rx_pin_i, .tx_pin_o, .serial_data_buffer_o,
        .received_ninth_bit_o, .transmit_done_flag_o, .receive_done_flag_o, .interrupt_request_o, .transmit_busy_o);
    asp_remote_port asp_remote_port_inst (.core_clk_i, .tx_line_i(tx_pin_o), .nine_bits_i(frame_length_select_i),
        .bit_cycles_i(bit_cycles), .rx_line_o(rx_pin_i), .captured_o(captured), .frame_count_o(frame_count));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        ext_osc_clk_i <= ~ext_osc_clk_i;
        timer_external_input_i <= ~timer_external_input_i;
    end
    // -----
    // tasks
    // -----
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic pulse(input int w, input logic [7:0] v);
        @(posedge core_clk_i);
        data_write_i <= (w == 0);
        transmit_done_clear_i <= (w == 1);
        receive_done_clear_i <= (w == 2);
        data_write_value_i <= v;
        @(posedge core_clk_i);
        data_write_i <= 1'b0;
        transmit_done_clear_i <= 1'b0;
        receive_done_clear_i <= 1'b0;
    endtask : pulse
    task automatic wait_until(input int w);
        int k;
        for (k = 0; k < 5000; k++) begin
            @(negedge core_clk_i);
            if (w == 0 ? transmit_busy_o === 1'b0 : receive_done_flag_o === 1'b1) break;
        end
        if (k == 5000) begin
            fail_count++;
            give_verdict();
        end
    endtask : wait_until
    task automatic rx_check(input string what, input logic [8:0] exp);
        check(what, {received_ninth_bit_o, serial_data_buffer_o}, exp);
    endtask : rx_check
    // --------
    // sequence
    // --------
    initial begin
        {reset_n_i, frame_length_select_i, multiproc_filter_on_i, receiver_on_i, transmit_ninth_bit_i} = 5'h00;
        {serial_interrupt_enable_i, timer_run_i, ext_osc_clk_i, timer_external_input_i, data_write_i} = 5'h00;
        {transmit_done_clear_i, receive_done_clear_i, timer_clock_select_i} = 5'h00;
        baud_reload_byte_i = 8'hFE;
        data_write_value_i = 8'h00;
        bit_cycles = 16'h0004;
        fail_count = 0;
        compares = 0;
        repeat (12) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        timer_run_i <= 1'b1;
        receiver_on_i <= 1'b1;
        serial_interrupt_enable_i <= 1'b1;
        for (int s = 0; s < 6; s++) begin
            @(posedge core_clk_i);
            timer_clock_select_i <= s[2:0];
            bit_cycles <= CYC[s];
            pulse(0, 8'h96 ^ s[7:0]);
            wait_until(0);
            check("tx frame", captured, {1'b1, 8'h96 ^ s[7:0]});
            check("tx done irq", {transmit_done_flag_o, interrupt_request_o}, 9'h003);
            pulse(1, 8'h00);
            @(negedge core_clk_i);
            check("tx done clear", transmit_done_flag_o, 9'h000);
        end
        @(posedge core_clk_i);
        timer_clock_select_i <= 3'h0;
        baud_reload_byte_i <= 8'hFC;
        bit_cycles <= 16'h0008;
        frame_length_select_i <= 1'b1;
        transmit_ninth_bit_i <= 1'b1;
        pulse(0, 8'h3C);
        pulse(0, 8'hFF);
        wait_until(0);
        check("nine bit tx", captured, 9'h13C);
        repeat (200) @(negedge core_clk_i);
        check("frames sent", frame_count, 9'h007);
        pulse(1, 8'h00);
        frame_length_select_i <= 1'b0;
        @(posedge core_clk_i);
        asp_remote_port_inst.send_frame(9'h05A);
        wait_until(1);
        rx_check("rx byte", 9'h15A);
        asp_remote_port_inst.send_frame(9'h0C3);
        repeat (20) @(negedge core_clk_i);
        rx_check("rx held", 9'h15A);
        pulse(2, 8'h00);
        wait_until(1);
        rx_check("rx second", 9'h1C3);
        pulse(2, 8'h00);
        frame_length_select_i <= 1'b1;
        multiproc_filter_on_i <= 1'b1;
        @(posedge core_clk_i);
        asp_remote_port_inst.send_frame(9'h011);
        repeat (20) @(negedge core_clk_i);
        check("filtered", receive_done_flag_o, 9'h000);
        asp_remote_port_inst.send_frame(9'h181);
        wait_until(1);
        rx_check("address", 9'h181);
        check("rx irq", interrupt_request_o, 9'h001);
        give_verdict();
    end
endmodule : asp_serial_port_tb
